// ---- rtl/ldcr_pkg.sv ----
// Operation
// - DC level: 256 linear current steps, live
// - DC level sets pulse on-time current
// - DC level byte write sets, read returns
// - DC level resets to full scale
// - Identity read-only: one, maker, revision
// - Maker codes 10-14 reserved, 15 none
// - Rate bit: 0 fast, 1 slow
// - Two-bit drive strength, four steps
// - Bit zero enables short detection
// - Configuration resets to 0x1F
// - Mask bits enable matching strings
// - Mask reads zero for disabled/faulted strings
// - Disable then enable retries faulted string
// - Mask resets to all six enabled
// - Bit seven: period over enabled count
// - Otherwise steps times period over 255
// - Phase register resets to zero
package ldcr_pkg;
    localparam int        NUM_STRINGS    = 6;
    localparam int        PERIOD_W       = 24;
    localparam logic [7:0] ADDR_IDENTITY = 8'h03;
    localparam logic [7:0] ADDR_DC_LEVEL = 8'h07;
    localparam logic [7:0] ADDR_CONFIG   = 8'h08;
    localparam logic [7:0] ADDR_MASK     = 8'h09;
    localparam logic [7:0] ADDR_PHASE    = 8'h0A;
    localparam logic [7:0] RST_DC_LEVEL  = 8'hFF;
    localparam logic [7:0] RST_CONFIG    = 8'h1F;
    localparam logic [7:0] RST_MASK      = 8'h3F;
    localparam logic [7:0] RST_PHASE     = 8'h00;
    localparam int        CFG_SHORT_BIT  = 0;
    localparam int        CFG_RATE_BIT   = 2;
    localparam int        CFG_DRIVE_LO   = 3;
    localparam int        PH_EVEN_BIT    = 7;
    localparam int        PH_STEP_DIV    = 255;
    localparam logic [3:0] MAKER_NONE    = 4'hF;
    localparam logic [3:0] MAKER_RSV_LO  = 4'hA;
    localparam logic [3:0] MAKER_RSV_HI  = 4'hE;
endpackage

// ---- rtl/ldcr_delay_calc.sv ----
`timescale 1ns/1ns
// Per-string start offsets from the start of a dimming period, not wrapped to one period
module ldcr_delay_calc
    import ldcr_pkg::*;
#(
    parameter int NS = ldcr_pkg::NUM_STRINGS,
    parameter int PW = ldcr_pkg::PERIOD_W
) (
    // Clock and reset
    input  wire logic            clock,
    input  wire logic            rst,
    // Settings
    input  wire logic [7:0]      phaseSetting,
    input  wire logic [NS-1:0]   laneActive,
    input  wire logic [PW-1:0]   dimPeriod,
    // Offsets in clock cycles
    output logic [NS*PW-1:0]     startOffset
);
    import ldcr_pkg::*;

    logic [PW-1:0]    stepDelay;
    logic [3:0]       enabledCount;
    logic [NS*PW-1:0] offs_reg;
    logic [NS*PW-1:0] offs_next;
    logic [PW+7:0]    prod;

    always_comb begin
        enabledCount = 4'h0;
        for (int i = 0; i < NS; i++) begin
            enabledCount = enabledCount + {3'h0, laneActive[i]};
        end
        prod = dimPeriod * phaseSetting[6:0];
        if (phaseSetting[PH_EVEN_BIT]) begin
            stepDelay = (enabledCount == 4'h0) ? '0 : PW'(dimPeriod / enabledCount);
        end else begin
            stepDelay = PW'(prod / PH_STEP_DIV);
        end
    end

    always_comb begin
        logic [PW-1:0] acc;
        logic          first;
        acc       = '0;
        first     = 1'b1;
        offs_next = '0;
        for (int i = 0; i < NS; i++) begin
            if (laneActive[i]) begin
                if (!first) begin
                    acc = acc + stepDelay;
                end
                first = 1'b0;
                offs_next[i*PW +: PW] = acc;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            offs_reg <= '0;
        end else begin
            offs_reg <= offs_next;
        end
    end

    assign startOffset = offs_reg;
endmodule

// ---- rtl/ldcr_regs.sv ----
`timescale 1ns/1ns
// Register bank of the six-string backlight driver
module ldcr_regs
    import ldcr_pkg::*;
#(
    parameter logic [3:0] MAKER_CODE = 4'h5, // Arbitrary value
    parameter logic [2:0] REVISION   = 3'h0
) (
    // Clock and reset
    input  wire logic                          clock,
    input  wire logic                          rst,
    // Byte register port from the serial interface
    input  wire logic                          regWrite,
    input  wire logic                          regRead,
    input  wire logic [7:0]                    regAddr,
    input  wire logic [7:0]                    regWdata,
    output logic [7:0]                         regRdata,
    // Analog side
    input  wire logic [ldcr_pkg::NUM_STRINGS-1:0] stringFault,
    input  wire logic [ldcr_pkg::PERIOD_W-1:0]    dimPeriod,
    output logic [7:0]                         dcLevelBits,
    output logic [7:0]                         pulseCurrent,
    input  wire logic                          pulseOn,
    output logic                               switchingRateSelect,
    output logic [1:0]                         switchDriveStrength,
    output logic                               shortDetectEnable,
    output logic [ldcr_pkg::NUM_STRINGS-1:0]   laneEnableBits,
    output logic [ldcr_pkg::NUM_STRINGS*ldcr_pkg::PERIOD_W-1:0] startOffset
);
    import ldcr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [7:0]             dc_reg, dc_next;
    logic [7:0]             cfg_reg, cfg_next;
    logic [7:0]             mask_reg, mask_next;
    logic [7:0]             ph_reg, ph_next;
    logic [NUM_STRINGS-1:0] shut_reg, shut_next;
    logic [7:0]             rd_reg, rd_next;
    logic [NUM_STRINGS-1:0] laneActive;
    logic [3:0]             makerShown;
    logic [NUM_STRINGS-1:0] f1_reg, f2_reg;
    logic [7:0]             pc_reg, pc_next;

    ////////////////////////////////////////////////////////////////////////
    // Fault inputs come from the analog domain
    always_ff @(posedge clock) begin
        if (rst) begin
            f1_reg <= '0;
            f2_reg <= '0;
        end else begin
            f1_reg <= stringFault;
            f2_reg <= f1_reg;
        end
    end

    always_comb begin
        if (MAKER_CODE >= MAKER_RSV_LO && MAKER_CODE <= MAKER_RSV_HI) begin
            makerShown = MAKER_NONE;
        end else begin
            makerShown = MAKER_CODE;
        end
    end

    always_comb begin
        dc_next   = dc_reg;
        cfg_next  = cfg_reg;
        mask_next = mask_reg;
        ph_next   = ph_reg;
        // Latch faults on enabled strings
        shut_next = shut_reg | (f2_reg & mask_reg[NUM_STRINGS-1:0]);
        if (regWrite) begin
            case (regAddr)
                ADDR_DC_LEVEL: dc_next = regWdata;
                ADDR_CONFIG:   cfg_next = regWdata;
                ADDR_MASK: begin
                    mask_next = regWdata;
                    shut_next = shut_next & regWdata[NUM_STRINGS-1:0];
                end
                ADDR_PHASE:    ph_next = regWdata;
                default:       ;
            endcase
        end
    end

    always_comb begin
        rd_next = rd_reg;
        if (regRead) begin
            case (regAddr)
                ADDR_IDENTITY: rd_next = {1'b1, makerShown, REVISION};
                ADDR_DC_LEVEL: rd_next = dc_reg;
                ADDR_CONFIG:   rd_next = cfg_reg;
                ADDR_MASK:     rd_next = {mask_reg[7:NUM_STRINGS], laneActive};
                ADDR_PHASE:    rd_next = ph_reg;
                default:       rd_next = 8'h00;
            endcase
        end
    end

    always_comb begin
        pc_next = pulseOn ? dc_reg : 8'h00;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            dc_reg   <= RST_DC_LEVEL;
            cfg_reg  <= RST_CONFIG;
            mask_reg <= RST_MASK;
            ph_reg   <= RST_PHASE;
            shut_reg <= '0;
            rd_reg   <= 8'h00;
            pc_reg   <= 8'h00;
        end else begin
            dc_reg   <= dc_next;
            cfg_reg  <= cfg_next;
            mask_reg <= mask_next;
            ph_reg   <= ph_next;
            shut_reg <= shut_next;
            rd_reg   <= rd_next;
            pc_reg   <= pc_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-string enable
    assign laneActive          = mask_reg[NUM_STRINGS-1:0] & ~shut_reg;
    assign laneEnableBits      = laneActive;
    assign dcLevelBits         = dc_reg;
    assign pulseCurrent        = pc_reg;
    assign regRdata            = rd_reg;
    assign switchingRateSelect = cfg_reg[CFG_RATE_BIT];
    assign switchDriveStrength = cfg_reg[CFG_DRIVE_LO +: 2];
    assign shortDetectEnable   = cfg_reg[CFG_SHORT_BIT];

    ldcr_delay_calc #(
        .NS (NUM_STRINGS),
        .PW (PERIOD_W)
    ) u_delay (
        .clock        (clock),
        .rst          (rst),
        .phaseSetting (ph_reg),
        .laneActive   (laneActive),
        .dimPeriod    (dimPeriod),
        .startOffset  (startOffset)
    );
endmodule

// ---- dv/ldcr_regs_props.sv ----
`timescale 1ns/1ns
module ldcr_regs_props
    import ldcr_pkg::*;
#(parameter logic [3:0] MAKER_CODE = 4'h5, parameter logic [2:0] REVISION = 3'h0) (
    // Clock, reset and byte port
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    // Analog side
    input wire logic [7:0] dcLevelBits,
    input wire logic [7:0] pulseCurrent,
    input wire logic       pulseOn,
    input wire logic       switchingRateSelect,
    input wire logic [1:0] switchDriveStrength,
    input wire logic       shortDetectEnable,
    input wire logic [5:0] laneEnableBits
);
    // Reserved maker codes read back as not implemented
    localparam logic [3:0] MK = (MAKER_CODE >= MAKER_RSV_LO && MAKER_CODE <= MAKER_RSV_HI) ?
        MAKER_NONE : MAKER_CODE;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_dc_reset:
    assert property ($fell(rst) |-> dcLevelBits == 8'hFF) else $error("dc level reset");
    a_mask_reset:
    assert property ($fell(rst) |-> laneEnableBits == 6'h3F) else $error("mask reset");
    a_dc_write:
    assert property (regWrite && regAddr == ADDR_DC_LEVEL |=> dcLevelBits == $past(regWdata))
        else $error("dc level write");
    a_cfg_fields:
    assert property (regWrite && regAddr == ADDR_CONFIG |=> {3'h0, switchDriveStrength,
        switchingRateSelect, 1'b0, shortDetectEnable} == ($past(regWdata) & 8'h1D))
        else $error("config outputs");
    a_pulse_level:
    assert property (pulseOn |=> pulseCurrent == $past(dcLevelBits)) else $error("pulse level");
    a_id_read:
    assert property (regRead && regAddr == ADDR_IDENTITY |=> regRdata == {1'b1, MK, REVISION})
        else $error("identity read");
    a_mask_read:
    assert property (regRead && regAddr == ADDR_MASK |=> regRdata[5:0] == $past(laneEnableBits))
        else $error("mask read");
    a_mask_write:
    assert property (regWrite && regAddr == ADDR_MASK |=>
        ({2'b00, laneEnableBits} & ~$past(regWdata)) == 8'h00) else $error("mask write");
    cover property (regWrite && regAddr == ADDR_CONFIG);
    cover property (regRead && regAddr == ADDR_MASK && laneEnableBits != 6'h3F);
    cover property (pulseOn ##1 pulseCurrent != 8'h00);
endmodule
bind ldcr_regs ldcr_regs_props #(.MAKER_CODE(MAKER_CODE), .REVISION(REVISION)) ldcr_regs_props_i (
    .clock(clock), .rst(rst), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .dcLevelBits(dcLevelBits),
    .pulseCurrent(pulseCurrent), .pulseOn(pulseOn), .switchingRateSelect(switchingRateSelect),
    .switchDriveStrength(switchDriveStrength), .shortDetectEnable(shortDetectEnable),
    .laneEnableBits(laneEnableBits));

// ---- dv/ldcr_host.sv ----
`timescale 1ns/1ns
module ldcr_host (
    // Clock
    input  wire logic       clock,
    // Byte register port
    output logic            regWrite,
    output logic            regRead,
    output logic [7:0]      regAddr,
    output logic [7:0]      regWdata,
    input  wire logic [7:0] regRdata
);
    initial {regWrite, regRead, regAddr, regWdata} = 18'h0_0000;
    // One byte cycle; on release both strobes drop, address and data lines show the inverse of their last value
    task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        @(negedge clock);
        {regWrite, regRead, regAddr, regWdata} = {w, !w, a, d};
        @(negedge clock);
        {regWrite, regRead, regAddr, regWdata} = {2'b00, ~a, ~d};
        q = regRdata;
    endtask
endmodule

// ---- dv/tb_ldcr_regs.sv ----
`timescale 1ns/1ns
module tb_ldcr_regs;
    import ldcr_pkg::*;
    typedef struct packed {logic w; logic [7:0] a, d, e;} ldcr_row_t;
    logic clock = 0, rst = 1, pulseOn = 0, regWrite, regRead, rate, shortEn;
    logic [7:0] regAddr, regWdata, regRdata, dcLevelBits, pulseCurrent, q;
    logic [5:0] stringFault = 6'h00, laneEnableBits;
    logic [23:0] dimPeriod = 24'h00_0258;
    logic [143:0] startOffset;
    logic [1:0] drive;
    int bad_count = 0, comparisons = 0, cycles = 0;
    ldcr_row_t rows [10] = '{
        '{1'b0, 8'h07, 8'h00, 8'hFF}, '{1'b0, 8'h08, 8'h00, 8'h1F}, '{1'b0, 8'h09, 8'h00, 8'h3F},
        '{1'b0, 8'h0A, 8'h00, 8'h00}, '{1'b0, 8'h03, 8'h00, 8'hA8}, '{1'b1, 8'h03, 8'h55, 8'hA8},
        '{1'b1, 8'h07, 8'h40, 8'h40}, '{1'b1, 8'h08, 8'hA5, 8'hA5}, '{1'b1, 8'h20, 8'h55, 8'h00},
        '{1'b1, 8'h0A, 8'h03, 8'h03}};
    ldcr_regs ldcr_regs_i (.clock(clock), .rst(rst), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .pulseOn(pulseOn),
        .stringFault(stringFault), .dimPeriod(dimPeriod), .dcLevelBits(dcLevelBits),
        .pulseCurrent(pulseCurrent), .switchingRateSelect(rate), .switchDriveStrength(drive),
        .shortDetectEnable(shortEn), .laneEnableBits(laneEnableBits), .startOffset(startOffset));
    ldcr_host ldcr_host_i (.clock(clock), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));
    always #2 clock = ~clock;
    task automatic conclude();
        $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic chk(input logic [23:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        ldcr_host_i.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a);
        ldcr_host_i.xfer(1'b0, a, 8'h00, q);
    endtask
    initial begin
        repeat (16) @(negedge clock);
        rst = 0;
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            chk(q, rows[i].e);
        end
        for (int d = 0; d < 4; d++) begin
            wr(ADDR_CONFIG, 8'(d * 8 + (d % 2) * 5));
            chk({drive, rate, shortEn}, 24'(d * 4 + (d % 2) * 3));
        end
        chk(startOffset[120+:24], 24'h00_0023);
        wr(ADDR_MASK, 8'h2D);
        wr(ADDR_PHASE, 8'h80);
        @(negedge clock);
        chk(startOffset[48+:24], 24'h00_0096);
        chk(startOffset[120+:24], 24'h00_01C2);
        stringFault = 6'h08;
        repeat (4) @(negedge clock);
        rd(ADDR_MASK);
        chk(q, 8'h25);
        chk(startOffset[120+:24], 24'h00_0190);
        stringFault = 6'h00;
        wr(ADDR_MASK, 8'h25);
        wr(ADDR_MASK, 8'h2D);
        rd(ADDR_MASK);
        chk(q, 8'h2D);
        pulseOn = 1;
        wr(ADDR_DC_LEVEL, 8'h80);
        @(negedge clock);
        chk(pulseCurrent, 8'h80);
        pulseOn = 0;
        rst = 1;
        repeat (2) @(negedge clock);
        rst = 0;
        rd(ADDR_DC_LEVEL);
        chk(q, 8'hFF);
        conclude();
    end
endmodule
